// [pkg/hisup_pkg.sv]
// Package: constants, modes and carriers of the heat impulse supervision block
package hisup_pkg;

	// Clock and tick
	localparam int unsigned CLK_HZ        = 50000000;
	localparam int unsigned TICK_MS       = 1;
	localparam int unsigned TICK_CYC      = CLK_HZ / 1000 * TICK_MS;

	// Timing figures in milliseconds
	localparam int unsigned COMP_GAP_MS   = 2000;
	localparam int unsigned COMP_RUN_MS   = 2000;
	localparam int unsigned HOLD2_MS      = 2000;
	localparam int unsigned DECI_MS       = 100;
	localparam int unsigned BLINK_MS      = 250;

	// Measuring impulse length in microseconds, and cycles per microsecond
	localparam int unsigned MEAS_US_DEF   = 1700;
	localparam int unsigned CYC_PER_US    = CLK_HZ / 1000000;

	// Parameter ranges and defaults
	localparam logic signed [15:0] CAL_DEF    = 16'sh0014;
	localparam logic signed [15:0] CAL_MIN    = 16'sh0000;
	localparam logic signed [15:0] CAL_MAX    = 16'sh0028;
	localparam logic signed [15:0] CAL_CYCLIC = 16'shFFFF;
	localparam logic [9:0]         HTL_MAX    = 10'h3E7;
	localparam logic [6:0]         DIAG_MAX   = 7'h63;
	localparam logic [15:0]        HEAT_PCT   = 16'h005F;
	localparam logic [15:0]        ANA_ZERO   = 16'h0000;

	// Error codes
	localparam logic [15:0] ERR_NONE   = 16'h0000;
	localparam logic [15:0] ERR_HEATUP = 16'h0130;
	localparam logic [15:0] ERR_DIAG_LO = 16'h0135;
	localparam logic [15:0] ERR_DIAG_HI = 16'h0136;

	// AXI4-Lite register byte addresses
	localparam logic [7:0] A_CTRL    = 8'h00;
	localparam logic [7:0] A_CAL     = 8'h04;
	localparam logic [7:0] A_HTL     = 8'h08;
	localparam logic [7:0] A_MEAS    = 8'h0C;
	localparam logic [7:0] A_WIN     = 8'h10;
	localparam logic [7:0] A_DIAG    = 8'h14;
	localparam logic [7:0] A_HEATUP  = 8'h18;
	localparam logic [7:0] A_STATUS  = 8'h1C;
	localparam logic [7:0] A_REPORT  = 8'h20;

	// CTRL field positions
	localparam int unsigned F_BIGEND  = 0;
	localparam int unsigned F_COMP    = 1;
	localparam int unsigned F_HOLD    = 3;
	localparam int unsigned F_HUEN    = 5;

	localparam logic [1:0] AXI_OKAY   = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		COMP_OFF  = 2'b00,
		COMP_ON   = 2'b01,
		COMP_AUTO = 2'b10
	} hisup_comp_e;

	typedef enum logic [1:0] {
		HOLD_OFF = 2'b00,
		HOLD_ON  = 2'b01,
		HOLD_2S  = 2'b10
	} hisup_hold_e;

	typedef enum logic [1:0] {
		CAL_IDLE = 2'b00,
		CAL_RUN  = 2'b01,
		CAL_COMP = 2'b10
	} hisup_cal_e;

	// Cyclic data from the fieldbus master
	typedef struct packed {
		logic        heat_request_bit;
		logic        calibration_request;
		logic [15:0] set_point;
	} hisup_cyc_in_s;

	// Cyclic data back to the fieldbus master
	typedef struct packed {
		logic        temp_in_window_bit;
		logic        alarm;
		logic [15:0] actual_temp;
		logic [15:0] error_code;
	} hisup_cyc_out_s;

endpackage : hisup_pkg

// [core/hisup_top.sv]
// Heat impulse supervision: parameters, timers, error and hold logic
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Calibration temperature defaults to 20 and accepts 0 to 40.
// - Parameter minus one takes calibration temperature from the cyclic field.
// - Calibration temperature change applies without new zero calibration.
// - Heat request longer than time limit switches the heating impulse off.
// - Heating time limit 0 to 999 tenths; zero disables, default zero.
// - Measuring impulse length configurable, default 1.7 ms; MEAS_CYC_O saturates at 0xFFFF cycles (1310.7 us).
// - Data format selects little or big endian for all cyclic data.
// - Phase compensation off, on or automatic; off is default.
// - On: second zero calibration within 2 s gains compensation, lasting 2 s.
// - On: gap above 2 s gives ordinary zero calibration.
// - During compensation blink indicator and drive analog output to zero level.
// - Automatic: compensation after every successful zero calibration.
// - Temperature outside band when start drops gives error 309 or 310.
// - Diagnosis delay 0 to 9.9 s from first low limit crossing.
// - Diagnosis uses same limits as the in-window status bit.
// - Heatup timer from heat request; not reaching 95% gives error 304.
// - Heatup timeout supervision off by default, enabled by parameter.
// - Hold off reports real-time actual temperature.
// - Hold on reports value latched at end of last sealing phase.
// - Two-second hold freezes report 2 s after each sealing phase.
// - Hold affects only fieldbus report; analog output stays real-time. The AXI REPORT register also returns the held value.
// - Tolerance window has separate low and high thresholds.
module hisup_top (
	input  wire logic                     MCLK_I,
	input  wire logic                     NRST_I,
	input  wire logic [7:0]               AWADDR_I,
	input  wire logic                     AWVALID_I,
	output logic                          AWREADY_O,
	input  wire logic [31:0]              WDATA_I,
	input  wire logic [3:0]               WSTRB_I,
	input  wire logic                     WVALID_I,
	output logic                          WREADY_O,
	output logic [1:0]                    BRESP_O,
	output logic                          BVALID_O,
	input  wire logic                     BREADY_I,
	input  wire logic [7:0]               ARADDR_I,
	input  wire logic                     ARVALID_I,
	output logic                          ARREADY_O,
	output logic [31:0]                   RDATA_O,
	output logic [1:0]                    RRESP_O,
	output logic                          RVALID_O,
	input  wire logic                     RREADY_I,
	input  wire hisup_pkg::hisup_cyc_in_s CYC_IN_I,
	input  wire logic                     CYC_IN_SWAP_I,
	input  wire logic [15:0]              TEMP_REAL_I,
	input  wire logic                     CAL_DONE_I,
	input  wire logic                     CAL_OK_I,
	output hisup_pkg::hisup_cyc_out_s     CYC_OUT_O,
	output logic                          HEAT_EN_O,
	output logic                          CAL_RUN_O,
	output logic                          COMP_RUN_O,
	output logic [15:0]                   CAL_TEMP_O,
	output logic [15:0]                   MEAS_CYC_O,
	output logic [15:0]                   ANALOG_O,
	output logic                          LED_OUT_O
);
	import hisup_pkg::*;

	// Registers
	logic        big_end_ff;
	hisup_comp_e comp_mode_ff;
	hisup_hold_e hold_mode_ff;
	logic        hu_en_ff;
	logic signed [15:0] cal_par_ff;
	logic [9:0]  htl_ff;
	logic [15:0] meas_us_ff;
	logic [15:0] win_lo_ff, win_hi_ff;
	logic [6:0]  diag_dly_ff;
	logic [9:0]  hu_time_ff;

	// Byte order: cyclic in raw, normalised here
	logic [15:0] sp_raw, set_point;
	assign sp_raw = CYC_IN_I.set_point;
	assign set_point = (CYC_IN_SWAP_I ^ big_end_ff) ? {sp_raw[7:0], sp_raw[15:8]} : sp_raw;

	// AXI4-Lite write path
	logic        aw_got_ff, w_got_ff;
	logic [7:0]  aw_addr_ff;
	logic [31:0] w_data_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        do_wr;
	assign AWREADY_O = !aw_got_ff && !bvalid_ff;
	assign WREADY_O  = !w_got_ff && !bvalid_ff;
	assign do_wr     = aw_got_ff && w_got_ff && !bvalid_ff;
	assign BVALID_O  = bvalid_ff;
	assign BRESP_O   = bresp_ff;

	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			aw_got_ff  <= 1'b0;
			w_got_ff   <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_data_ff  <= 32'h0000_0000;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= AXI_OKAY;
		end else begin
			if (AWVALID_I && AWREADY_O) begin
				aw_got_ff  <= 1'b1;
				aw_addr_ff <= AWADDR_I;
			end
			if (WVALID_I && WREADY_O) begin
				w_got_ff  <= 1'b1;
				w_data_ff <= WDATA_I;
			end
			if (do_wr) begin
				aw_got_ff <= 1'b0;
				w_got_ff  <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff  <= (aw_addr_ff <= A_HEATUP && aw_addr_ff[1:0] == 2'b00) ?
					AXI_OKAY : AXI_SLVERR;
			end else if (bvalid_ff && BREADY_I) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// Parameter registers; byte strobes only block a write when all are zero, otherwise whole word written
	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			big_end_ff   <= 1'b0;
			comp_mode_ff <= COMP_OFF;
			hold_mode_ff <= HOLD_OFF;
			hu_en_ff     <= 1'b0;
			cal_par_ff   <= CAL_DEF;
			htl_ff       <= 10'h000;
			meas_us_ff   <= 16'(MEAS_US_DEF);
			win_lo_ff    <= 16'h0000;
			win_hi_ff    <= 16'hFFFF;
			diag_dly_ff  <= 7'h00;
			hu_time_ff   <= 10'h000;
		end else if (do_wr && WSTRB_I != 4'h0) begin
			unique case (aw_addr_ff)
				A_CTRL: begin
					big_end_ff <= w_data_ff[F_BIGEND];
					if (w_data_ff[F_COMP+:2] != 2'b11)
						comp_mode_ff <= hisup_comp_e'(w_data_ff[F_COMP+:2]);
					if (w_data_ff[F_HOLD+:2] != 2'b11)
						hold_mode_ff <= hisup_hold_e'(w_data_ff[F_HOLD+:2]);
					hu_en_ff <= w_data_ff[F_HUEN];
				end
				A_CAL: begin
					if (($signed(w_data_ff[15:0]) >= CAL_MIN && $signed(w_data_ff[15:0]) <= CAL_MAX)
						|| w_data_ff[15:0] == CAL_CYCLIC)
						cal_par_ff <= w_data_ff[15:0];
				end
				A_HTL: begin
					htl_ff <= (w_data_ff[9:0] > HTL_MAX) ? HTL_MAX : w_data_ff[9:0];
				end
				A_MEAS: meas_us_ff <= (w_data_ff[15:0] == 16'h0000) ? 16'h0001 : w_data_ff[15:0];
				A_WIN: begin
					win_lo_ff <= w_data_ff[15:0];
					win_hi_ff <= w_data_ff[31:16];
				end
				A_DIAG: diag_dly_ff <= (w_data_ff[6:0] > DIAG_MAX) ? DIAG_MAX : w_data_ff[6:0];
				A_HEATUP: hu_time_ff <= w_data_ff[9:0];
				default: ;
			endcase
		end
	end

	assign MEAS_CYC_O = 16'(32'(meas_us_ff) * CYC_PER_US > 32'hFFFF ? 32'hFFFF :
		32'(meas_us_ff) * CYC_PER_US);

	assign CAL_TEMP_O = (cal_par_ff == CAL_CYCLIC) ? set_point : cal_par_ff;

	logic [15:0] tick_cnt_ff;
	logic        tick;
	assign tick = (tick_cnt_ff == 16'(TICK_CYC - 1));
	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) tick_cnt_ff <= 16'h0000;
		else tick_cnt_ff <= tick ? 16'h0000 : tick_cnt_ff + 16'h0001;
	end

	logic heat_req, heat_prev_ff, heat_rise, heat_fall;
	assign heat_req  = CYC_IN_I.heat_request_bit;
	assign heat_rise = heat_req && !heat_prev_ff;
	assign heat_fall = !heat_req && heat_prev_ff;

	// Heating time limit
	logic [16:0] heat_ms_ff;
	logic        cutoff_ff;
	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			heat_prev_ff <= 1'b0;
			heat_ms_ff   <= 17'h00000;
			cutoff_ff    <= 1'b0;
		end else begin
			heat_prev_ff <= heat_req;
			if (!heat_req) begin
				heat_ms_ff <= 17'h00000;
				cutoff_ff  <= 1'b0;
			end else begin
				if (tick && heat_ms_ff != 17'h1FFFF) heat_ms_ff <= heat_ms_ff + 17'h00001;
				if (htl_ff != 10'h000 && heat_ms_ff >= 17'(htl_ff) * 17'(DECI_MS))
					cutoff_ff <= 1'b1;
			end
		end
	end
	assign HEAT_EN_O = heat_req && !cutoff_ff && !CAL_RUN_O;

	// Zero calibration and compensation sequencer
	hisup_cal_e  cal_st_ff;
	logic [11:0] gap_ms_ff, comp_ms_ff;
	logic        recent_ff, comp_req_ff;
	logic        cal_req_prev_ff, cal_start;
	assign cal_start = CYC_IN_I.calibration_request && !cal_req_prev_ff && cal_st_ff == CAL_IDLE;
	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			cal_st_ff       <= CAL_IDLE;
			gap_ms_ff       <= 12'h000;
			comp_ms_ff      <= 12'h000;
			recent_ff       <= 1'b0;
			comp_req_ff     <= 1'b0;
			cal_req_prev_ff <= 1'b0;
		end else begin
			cal_req_prev_ff <= CYC_IN_I.calibration_request;
			unique case (cal_st_ff)
				CAL_IDLE: begin
					if (tick && gap_ms_ff < 12'(COMP_GAP_MS)) gap_ms_ff <= gap_ms_ff + 12'h001;
					if (gap_ms_ff >= 12'(COMP_GAP_MS)) recent_ff <= 1'b0;
					if (cal_start) begin
						cal_st_ff   <= CAL_RUN;
						comp_req_ff <= comp_mode_ff == COMP_ON && recent_ff
							&& gap_ms_ff < 12'(COMP_GAP_MS);
					end
				end
				CAL_RUN: if (CAL_DONE_I) begin
					gap_ms_ff  <= 12'h000;
					comp_ms_ff <= 12'h000;
					recent_ff  <= CAL_OK_I && !comp_req_ff;
					if (CAL_OK_I && ((comp_req_ff && comp_mode_ff == COMP_ON)
						|| comp_mode_ff == COMP_AUTO))
						cal_st_ff <= CAL_COMP;
					else
						cal_st_ff <= CAL_IDLE;
				end
				CAL_COMP: begin
					if (tick) comp_ms_ff <= comp_ms_ff + 12'h001;
					if (comp_ms_ff >= 12'(COMP_RUN_MS - 1) && tick) begin
						cal_st_ff   <= CAL_IDLE;
						comp_req_ff <= 1'b0;
						recent_ff   <= 1'b0;
					end
				end
				default: cal_st_ff <= CAL_IDLE;
			endcase
		end
	end
	assign CAL_RUN_O  = cal_st_ff == CAL_RUN;
	assign COMP_RUN_O = cal_st_ff == CAL_COMP;

	logic blink_ff;
	logic [7:0] blink_ms_ff;
	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			blink_ff    <= 1'b0;
			blink_ms_ff <= 8'h00;
		end else if (!COMP_RUN_O) begin
			blink_ff    <= 1'b0;
			blink_ms_ff <= 8'h00;
		end else if (tick) begin
			blink_ms_ff <= (blink_ms_ff == 8'(BLINK_MS - 1)) ? 8'h00 : blink_ms_ff + 8'h01;
			if (blink_ms_ff == 8'(BLINK_MS - 1)) blink_ff <= !blink_ff;
		end
	end
	assign LED_OUT_O = COMP_RUN_O ? blink_ff : HEAT_EN_O;
	assign ANALOG_O  = COMP_RUN_O ? ANA_ZERO : TEMP_REAL_I;

	logic in_win, above_lo;
	assign above_lo = TEMP_REAL_I >= win_lo_ff;
	assign in_win   = above_lo && TEMP_REAL_I <= win_hi_ff;

	// Diagnosis, heatup and error latch
	logic [13:0] dly_ms_ff;
	logic        lo_seen_ff, diag_act_ff, alarm_ff, hu_done_ff;
	logic [15:0] err_ff;
	// Wide enough for the longest heatup time in milliseconds
	logic [16:0] hu_ms_ff;
	logic [25:0] sp95;
	assign sp95 = 26'(set_point) * 26'(HEAT_PCT);
	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			dly_ms_ff   <= 14'h0000;
			lo_seen_ff  <= 1'b0;
			diag_act_ff <= 1'b0;
			hu_ms_ff    <= 17'h00000;
			hu_done_ff  <= 1'b0;
			err_ff      <= ERR_NONE;
			alarm_ff    <= 1'b0;
		end else begin
			if (heat_rise) begin
				lo_seen_ff  <= 1'b0;
				diag_act_ff <= 1'b0;
				dly_ms_ff   <= 14'h0000;
				hu_ms_ff    <= 17'h00000;
				hu_done_ff  <= 1'b0;
			end else if (heat_req) begin
				if (above_lo) lo_seen_ff <= 1'b1;
				if (lo_seen_ff && tick && !diag_act_ff) dly_ms_ff <= dly_ms_ff + 14'h0001;
				if (lo_seen_ff && in_win && dly_ms_ff >= 14'(diag_dly_ff) * 14'(DECI_MS))
					diag_act_ff <= 1'b1;
				if (32'(TEMP_REAL_I) * 100 >= 32'(sp95)) hu_done_ff <= 1'b1;
				if (tick && !hu_done_ff && hu_ms_ff != 17'h1FFFF) hu_ms_ff <= hu_ms_ff + 17'h00001;
				if (hu_en_ff && !hu_done_ff && hu_ms_ff >= 17'(hu_time_ff) * 17'(DECI_MS)
					&& hu_time_ff != 10'h000) begin
					err_ff   <= ERR_HEATUP;
					alarm_ff <= 1'b1;
				end
			end
			if (heat_fall && !diag_act_ff) begin
				err_ff   <= above_lo ? ERR_DIAG_HI : ERR_DIAG_LO;
				alarm_ff <= 1'b1;
			end else if (heat_rise) begin
				err_ff   <= ERR_NONE;
				alarm_ff <= 1'b0;
			end
		end
	end

	// Reported actual temperature with hold
	logic [15:0] held_ff, hold_ms_ff;
	logic        held_valid_ff, hold2_ff;
	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			held_ff       <= 16'h0000;
			held_valid_ff <= 1'b0;
			hold2_ff      <= 1'b0;
			hold_ms_ff    <= 16'h0000;
		end else begin
			if (heat_fall) begin
				held_ff       <= TEMP_REAL_I;
				held_valid_ff <= 1'b1;
				hold2_ff      <= 1'b1;
				hold_ms_ff    <= 16'h0000;
			end else if (hold2_ff && tick) begin
				hold_ms_ff <= hold_ms_ff + 16'h0001;
				if (hold_ms_ff >= 16'(HOLD2_MS - 1)) hold2_ff <= 1'b0;
			end
		end
	end

	logic [15:0] rep_temp, rep_err;
	always_comb begin
		unique case (hold_mode_ff)
			HOLD_ON: rep_temp = held_valid_ff ? held_ff : TEMP_REAL_I;
			HOLD_2S: rep_temp = hold2_ff ? held_ff : TEMP_REAL_I;
			default: rep_temp = TEMP_REAL_I;
		endcase
		rep_err = err_ff;
	end

	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			CYC_OUT_O <= '0;
		end else begin
			CYC_OUT_O.temp_in_window_bit <= in_win;
			CYC_OUT_O.alarm              <= alarm_ff;
			CYC_OUT_O.actual_temp <= big_end_ff ? {rep_temp[7:0], rep_temp[15:8]} : rep_temp;
			CYC_OUT_O.error_code  <= big_end_ff ? {rep_err[7:0], rep_err[15:8]} : rep_err;
		end
	end

	// AXI4-Lite read path
	logic        rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  rresp_ff;
	assign ARREADY_O = !rvalid_ff;
	assign RVALID_O  = rvalid_ff;
	assign RDATA_O   = rdata_ff;
	assign RRESP_O   = rresp_ff;
	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= AXI_OKAY;
		end else if (ARVALID_I && ARREADY_O) begin
			rvalid_ff <= 1'b1;
			rresp_ff  <= AXI_OKAY;
			unique case (ARADDR_I)
				A_CTRL:   rdata_ff <= {26'h0, hu_en_ff, hold_mode_ff, comp_mode_ff, big_end_ff};
				A_CAL:    rdata_ff <= {16'h0000, cal_par_ff};
				A_HTL:    rdata_ff <= {22'h0, htl_ff};
				A_MEAS:   rdata_ff <= {16'h0000, meas_us_ff};
				A_WIN:    rdata_ff <= {win_hi_ff, win_lo_ff};
				A_DIAG:   rdata_ff <= {25'h0, diag_dly_ff};
				A_HEATUP: rdata_ff <= {22'h0, hu_time_ff};
				A_STATUS: rdata_ff <= {24'h0, diag_act_ff, in_win, cal_st_ff, cutoff_ff,
					alarm_ff, hu_done_ff, heat_req};
				A_REPORT: rdata_ff <= {err_ff, rep_temp};
				default: begin
					rdata_ff <= 32'h0000_0000;
					rresp_ff <= AXI_SLVERR;
				end
			endcase
		end else if (rvalid_ff && RREADY_I) begin
			rvalid_ff <= 1'b0;
		end
	end

	a_cutoff_off_heat: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
		cutoff_ff |-> !HEAT_EN_O) else $error("heat enabled after cutoff");
	a_cutoff_needs_clear: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
		$fell(cutoff_ff) |-> !$past(heat_req)) else $error("cutoff cleared with request set");
	a_zero_limit_idle: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
		(htl_ff == 10'h000 && !cutoff_ff) |=> !cutoff_ff) else $error("cutoff with limit off");
	a_comp_analog_zero: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
		COMP_RUN_O |-> ANALOG_O == ANA_ZERO) else $error("analog not zero in compensation");
	a_comp_off_never: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
		(comp_mode_ff == COMP_OFF && !COMP_RUN_O) |=> !COMP_RUN_O)
		else $error("compensation started while off");
	a_comp_auto_start: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
		(cal_st_ff == CAL_RUN && CAL_DONE_I && CAL_OK_I && comp_mode_ff == COMP_AUTO)
		|=> COMP_RUN_O) else $error("automatic compensation missing");
	a_cal_source: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
		cal_par_ff == CAL_CYCLIC |-> CAL_TEMP_O == ((CYC_IN_SWAP_I ^ big_end_ff) ?
		{CYC_IN_I.set_point[7:0], CYC_IN_I.set_point[15:8]} : CYC_IN_I.set_point))
		else $error("cal source wrong");
	a_hold_off_live: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
		hold_mode_ff == HOLD_OFF |-> rep_temp == TEMP_REAL_I) else $error("hold off not live");
	a_err_until_clear: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
		(alarm_ff && !heat_rise) |=> alarm_ff) else $error("alarm dropped early");
	a_diag_err_fall: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
		(heat_fall && !diag_act_ff) |=> alarm_ff && (err_ff == ERR_DIAG_HI || err_ff == ERR_DIAG_LO))
		else $error("diagnosis error missing");

endmodule : hisup_top

`default_nettype wire

// [bench/hisup_plc_model.sv]
// Fieldbus master model driving the cyclic input word
`timescale 1ns/1ps
`default_nettype none
module hisup_plc_model (
	input  wire logic             clk_i,
	input  wire logic             nrst_i,
	input  wire logic             heat_i,
	input  wire logic             cal_i,
	input  wire logic [15:0]      sp_i,
	output hisup_pkg::hisup_cyc_in_s cyc_o
);
	import hisup_pkg::*;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cyc_o <= '0;
		end else begin
			cyc_o.heat_request_bit    <= heat_i;
			cyc_o.calibration_request <= cal_i;
			cyc_o.set_point           <= sp_i;
		end
	end
endmodule : hisup_plc_model
`default_nettype wire

// [bench/hisup_tb_top.sv]
// Testbench: scenarios for the heat impulse supervision block
`timescale 1ns/1ps
`default_nettype none
module hisup_tb_top;
	import hisup_pkg::*;
	logic           clk = 1'b0;
	logic           nrst = 1'b0;
	logic [7:0]     awaddr = 8'h00, araddr = 8'h00;
	logic           awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic           arvalid = 1'b0, rready = 1'b0;
	logic [31:0]    wdata = 32'h0;
	logic [15:0]    temp = 16'h0, sp = 16'h0;
	logic           heat = 1'b0, cal = 1'b0, cal_done = 1'b0, cal_ok = 1'b0;
	logic           awready, wready, bvalid, arready, rvalid, heat_en, cal_run, comp_run, led;
	logic [1:0]     bresp, rresp;
	logic [31:0]    rdata, d;
	logic [15:0]    cal_temp, meas_cyc, analog;
	hisup_cyc_in_s  cyc_in;
	hisup_cyc_out_s cyc_out;
	int             bad_count = 0, check_count = 0, cycles = 0;

	hisup_top u_hisup_top (.MCLK_I(clk), .NRST_I(nrst), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
		.AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(4'hF), .WVALID_I(wvalid),
		.WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
		.ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
		.RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready), .CYC_IN_I(cyc_in),
		.CYC_IN_SWAP_I(1'b0), .TEMP_REAL_I(temp), .CAL_DONE_I(cal_done), .CAL_OK_I(cal_ok),
		.CYC_OUT_O(cyc_out), .HEAT_EN_O(heat_en), .CAL_RUN_O(cal_run), .COMP_RUN_O(comp_run),
		.CAL_TEMP_O(cal_temp), .MEAS_CYC_O(meas_cyc), .ANALOG_O(analog), .LED_OUT_O(led));
	hisup_plc_model u_hisup_plc_model (.clk_i(clk), .nrst_i(nrst), .heat_i(heat), .cal_i(cal),
		.sp_i(sp), .cyc_o(cyc_in));

	always #10 clk = ~clk;

	task automatic conclude;
		$display("Checks %0d errors %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : conclude

	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			conclude();
		end
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, bresp});
		@(posedge clk);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		v = rdata;
		rready <= 1'b0;
		chk("rresp", {30'h0, er}, {30'h0, rresp});
		@(posedge clk);
	endtask : rd

	task automatic t_defaults;
		logic [7:0]  ad [6] = '{A_CTRL, A_CAL, A_HTL, A_MEAS, A_WIN, A_HEATUP};
		logic [31:0] ex [6] = '{32'h0, 32'h14, 32'h0, 32'h6A4, 32'hFFFF0000, 32'h0};
		foreach (ad[i]) begin
			rd(ad[i], d, AXI_OKAY);
			chk("default", ex[i], d);
		end
		rd(8'h40, d, AXI_SLVERR);
		chk("unmapped", 32'h0, d);
		chk("cal_temp", 32'h14, {16'h0, cal_temp});
		wr(A_MEAS, 32'h3E8, AXI_OKAY);
		chk("meas_cyc", 32'hC350, {16'h0, meas_cyc});
	endtask : t_defaults

	task automatic t_cal;
		wr(A_CAL, 32'h28, AXI_OKAY);
		chk("cal_max", 32'h28, {16'h0, cal_temp});
		wr(A_CAL, 32'h29, AXI_OKAY);
		chk("cal_over", 32'h28, {16'h0, cal_temp});
		sp <= 16'h0019;
		wr(A_CAL, 32'h0000FFFF, AXI_OKAY);
		cyc(2);
		chk("cal_cyclic", 32'h19, {16'h0, cal_temp});
		sp <= 16'h001E;
		cyc(3);
		chk("cal_change", 32'h1E, {16'h0, cal_temp});
		wr(A_CAL, 32'h0, AXI_OKAY);
		chk("cal_min", 32'h0, {16'h0, cal_temp});
	endtask : t_cal

	task automatic t_order;
		temp <= 16'h1234;
		cyc(3);
		chk("little", 32'h1234, {16'h0, cyc_out.actual_temp});
		wr(A_CTRL, 32'h1, AXI_OKAY);
		cyc(2);
		chk("big", 32'h3412, {16'h0, cyc_out.actual_temp});
		chk("analog", 32'h1234, {16'h0, analog});
		wr(A_CTRL, 32'h0, AXI_OKAY);
	endtask : t_order

	task automatic t_hold;
		wr(A_CTRL, 32'h08, AXI_OKAY);
		temp <= 16'h0050;
		heat <= 1'b1;
		cyc(4);
		chk("heat_en", 32'h1, {31'h0, heat_en});
		chk("live_first", 32'h50, {16'h0, cyc_out.actual_temp});
		heat <= 1'b0;
		cyc(3);
		temp <= 16'h0060;
		cyc(3);
		chk("hold_on", 32'h50, {16'h0, cyc_out.actual_temp});
		chk("analog_live", 32'h60, {16'h0, analog});
		wr(A_CTRL, 32'h10, AXI_OKAY);
		heat <= 1'b1;
		cyc(4);
		heat <= 1'b0;
		cyc(3);
		temp <= 16'h0070;
		cyc(3);
		chk("hold_2s", 32'h60, {16'h0, cyc_out.actual_temp});
		wr(A_CTRL, 32'h0, AXI_OKAY);
		cyc(2);
		chk("hold_off", 32'h70, {16'h0, cyc_out.actual_temp});
	endtask : t_hold

	task automatic t_diag;
		wr(A_WIN, 32'hFFFF0100, AXI_OKAY);
		heat <= 1'b1;
		cyc(4);
		chk("led_heat", 32'h1, {31'h0, led});
		heat <= 1'b0;
		cyc(4);
		chk("err_low", 32'h0135, {16'h0, cyc_out.error_code});
		chk("alarm_set", 32'h1, {31'h0, cyc_out.alarm});
		chk("out_win", 32'h0, {31'h0, cyc_out.temp_in_window_bit});
		temp <= 16'h0150;
		cyc(3);
		chk("err_held", 32'h0135, {16'h0, cyc_out.error_code});
		heat <= 1'b1;
		cyc(4);
		chk("err_clear", 32'h0, {31'h0, cyc_out.alarm});
		chk("in_win", 32'h1, {31'h0, cyc_out.temp_in_window_bit});
		heat <= 1'b0;
		cyc(4);
		chk("no_err", 32'h0, {16'h0, cyc_out.error_code});
	endtask : t_diag

	task automatic calib(input logic [31:0] ec);
		cal <= 1'b1;
		cyc(3);
		chk("cal_run", 32'h1, {31'h0, cal_run});
		cal <= 1'b0;
		cal_done <= 1'b1;
		cal_ok <= 1'b1;
		cyc(1);
		cal_done <= 1'b0;
		cyc(2);
		chk("comp_run", ec, {31'h0, comp_run});
	endtask : calib

	task automatic t_comp;
		calib(32'h0);
		wr(A_CTRL, 32'h4, AXI_OKAY);
		calib(32'h1);
		chk("analog_comp", 32'h0, {16'h0, analog});
		nrst <= 1'b0;
		cyc(2);
		nrst <= 1'b1;
		cyc(1);
		chk("comp_reset", 32'h0, {31'h0, comp_run});
		rd(A_CTRL, d, AXI_OKAY);
		chk("ctrl_reset", 32'h0, d);
		wr(A_CTRL, 32'h2, AXI_OKAY);
		calib(32'h0);
		calib(32'h1);
	endtask : t_comp

	initial begin
		cyc(2);
		nrst <= 1'b1;
		cyc(1);
		t_defaults();
		t_cal();
		t_order();
		t_hold();
		t_diag();
		t_comp();
		conclude();
	end
endmodule : hisup_tb_top
`default_nettype wire
